/* File: rrx_defs.vh */
// constants for the return and rotate execution block
// assumes inclusion by bare name from the design file
`ifndef RRX_DEFS_VH
`define RRX_DEFS_VH
// ************************************************
// register byte offsets
// ************************************************
`define RRX_OFF_EXEC 12'h000
`define RRX_OFF_STATUS 12'h004
`define RRX_OFF_ACCUM 12'h008
`define RRX_OFF_IRQCTL 12'h00C
`define RRX_OFF_PC 12'h010
`define RRX_OFF_PUSH 12'h014
`define RRX_OFF_TOP 12'h018
`define RRX_OFF_FILE 12'h200
`define RRX_OFF_FILE_END 13'h0400
// ************************************************
// field positions
// ************************************************
`define RRX_EXEC_LIT_LSB 0
`define RRX_EXEC_FADDR_LSB 8
`define RRX_EXEC_DEST_BIT 15
`define RRX_EXEC_OP_LSB 16
`define RRX_ST_CARRY_BIT 0
`define RRX_ST_BUSY_BIT 1
`define RRX_ST_DEPTH_LSB 4
`define RRX_GIE_BIT 7
// ************************************************
// operation codes
// ************************************************
`define RRX_OP_IRQ_RET 2'h0
`define RRX_OP_LIT_RET 2'h1
`define RRX_OP_ROT_LEFT 2'h2
`define RRX_OP_ROT_RIGHT 2'h3
// ************************************************
// reset values and timing
// ************************************************
`define RRX_RST_ACCUM 8'h00
`define RRX_RST_IRQCTL 8'h00
`define RRX_RST_PC 13'h0000
`define RRX_INSTR_DIV 4
`define RRX_RET_CYCLES 2
`define RRX_ROT_CYCLES 1
`define RRX_RESP_OKAY 2'h0
`define RRX_RESP_SLVERR 2'h2
`endif

/* File: rrx_exec.v */
// return and rotate execution unit with an axi4-lite register slave
// assumes one 25 mhz clock; software issues operations through the exec register
//
// How it works
// - irq return pops stack, loads pc
// - irq return sets gie, takes two cycles
// - literal return loads literal into accumulator
// - literal return loads pc from top, two cycles
// - left rotate through carry, bit7 to carry
// - dest zero writes accumulator, file untouched
// - dest one writes result back to file
// - right rotate through carry, bit0 to carry
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "rrx_defs.vh"

module rrx_exec #(
  parameter INSTR_DIV = `RRX_INSTR_DIV,
  parameter STACK_DEPTH = 16,
  parameter PTR_W = 4,
  parameter PC_W = 13,
  parameter FILE_WORDS = 128
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // core state seen by the rest of the cpu
  output wire [PC_W-1:0] pc_out,
  output wire global_irq_enable,
  output wire busy
);

  localparam ST_IDLE = 2'h0;
  localparam ST_PEND = 2'h1;
  localparam ST_TAIL = 2'h2;
  localparam [31:0] DIV_LAST_W = INSTR_DIV - 1;
  localparam [7:0] DIV_LAST = DIV_LAST_W[7:0];

  // ************************************************
  // instruction cycle divider
  // ************************************************
  reg [7:0] div_ff;
  wire cyc_en = (div_ff == DIV_LAST);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 8'h00;
    end else if (cyc_en) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ************************************************
  // core state
  // ************************************************
  reg [7:0] accumulator_ff;
  reg [7:0] irq_control_ff;
  reg carry_ff;
  reg [PC_W-1:0] pc_ff;
  reg [PTR_W-1:0] sp_ff;
  reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  reg [7:0] file_mem [0:FILE_WORDS-1];
  reg [1:0] st_ff;
  reg [1:0] op_ff;
  reg dest_ff;
  reg [6:0] faddr_ff;
  reg [7:0] lit_ff;

  wire [PTR_W-1:0] top_idx = sp_ff - {{(PTR_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] stack_top = stack_mem[top_idx];
  wire [7:0] fval = file_mem[faddr_ff];

  assign pc_out = pc_ff;
  assign global_irq_enable = irq_control_ff[`RRX_GIE_BIT];
  assign busy = (st_ff != ST_IDLE);

  // ************************************************
  // axi4-lite write channels
  // ************************************************
  reg aw_have_ff;
  reg w_have_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  // each channel may arrive first; hold it until the partner shows up
  assign s_axi_awready = !aw_have_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_have_ff && !s_axi_bvalid;
  wire wr_do = aw_have_ff && w_have_ff && !s_axi_bvalid;
  wire [11:0] wa = {awaddr_ff[11:2], 2'b00};
  // end bound kept one bit wider so the window top does not wrap to zero
  wire wa_file = (wa >= `RRX_OFF_FILE) && ({1'b0, wa} < `RRX_OFF_FILE_END);
  wire [6:0] wa_fidx = wa[8:2];
  wire wa_known = wa_file || (wa == `RRX_OFF_EXEC) || (wa == `RRX_OFF_STATUS) ||
                  (wa == `RRX_OFF_ACCUM) || (wa == `RRX_OFF_IRQCTL) ||
                  (wa == `RRX_OFF_PC) || (wa == `RRX_OFF_PUSH) || (wa == `RRX_OFF_TOP);
  wire lane0 = wstrb_ff[0];
  wire sw_exec = wr_do && (wa == `RRX_OFF_EXEC) && (st_ff == ST_IDLE);
  wire sw_push = wr_do && (wa == `RRX_OFF_PUSH);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RRX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_known ? `RRX_RESP_OKAY : `RRX_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************
  // execution sequencer
  // ************************************************
  wire exec_now = (st_ff == ST_PEND) && cyc_en;
  wire is_ret = (op_ff == `RRX_OP_IRQ_RET) || (op_ff == `RRX_OP_LIT_RET);
  wire is_rot = (op_ff == `RRX_OP_ROT_LEFT) || (op_ff == `RRX_OP_ROT_RIGHT);
  wire [7:0] rot_res = (op_ff == `RRX_OP_ROT_LEFT) ? {fval[6:0], carry_ff} :
                       {carry_ff, fval[7:1]};
  wire rot_carry = (op_ff == `RRX_OP_ROT_LEFT) ? fval[7] : fval[0];
  wire rot_to_file = exec_now && is_rot && dest_ff;
  wire rot_to_acc = exec_now && is_rot && !dest_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_IDLE;
      op_ff <= `RRX_OP_IRQ_RET;
      dest_ff <= 1'b0;
      faddr_ff <= 7'h00;
      lit_ff <= 8'h00;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (sw_exec) begin
            st_ff <= ST_PEND;
            op_ff <= wdata_ff[`RRX_EXEC_OP_LSB +: 2];
            dest_ff <= wdata_ff[`RRX_EXEC_DEST_BIT];
            faddr_ff <= wdata_ff[`RRX_EXEC_FADDR_LSB +: 7];
            lit_ff <= wdata_ff[`RRX_EXEC_LIT_LSB +: 8];
          end
        end
        ST_PEND: begin
          // returns hold a second instruction cycle, rotates finish now
          if (cyc_en) begin
            st_ff <= is_ret ? ST_TAIL : ST_IDLE;
          end
        end
        ST_TAIL: begin
          if (cyc_en) begin
            st_ff <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // architectural updates
  // ************************************************
  // the executing operation wins a same-cycle clash with a software write
  always @(posedge aclk) begin
    if (!aresetn) begin
      accumulator_ff <= `RRX_RST_ACCUM;
      irq_control_ff <= `RRX_RST_IRQCTL;
      carry_ff <= 1'b0;
      pc_ff <= `RRX_RST_PC;
      sp_ff <= {PTR_W{1'b0}};
    end else begin
      if (exec_now && op_ff == `RRX_OP_LIT_RET) begin
        accumulator_ff <= lit_ff;
      end else if (rot_to_acc) begin
        accumulator_ff <= rot_res;
      end else if (wr_do && wa == `RRX_OFF_ACCUM && lane0) begin
        accumulator_ff <= wdata_ff[7:0];
      end
      if (exec_now && op_ff == `RRX_OP_IRQ_RET) begin
        irq_control_ff[`RRX_GIE_BIT] <= 1'b1;
      end else if (wr_do && wa == `RRX_OFF_IRQCTL && lane0) begin
        irq_control_ff <= wdata_ff[7:0];
      end
      // returns leave carry alone; rotates touch nothing else of status
      if (exec_now && is_rot) begin
        carry_ff <= rot_carry;
      end else if (wr_do && wa == `RRX_OFF_STATUS && lane0) begin
        carry_ff <= wdata_ff[`RRX_ST_CARRY_BIT];
      end
      if (exec_now && is_ret) begin
        pc_ff <= stack_top;
      end else if (exec_now) begin
        pc_ff <= pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
      end
      // a push beside a rotate must still advance the pointer
      if (exec_now && is_ret) begin
        sp_ff <= top_idx;
      end else if (sw_push) begin
        sp_ff <= sp_ff + {{(PTR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // stack overflow wraps the pointer, as a plain circular store
  always @(posedge aclk) begin
    if (sw_push && !(exec_now && is_ret)) begin
      stack_mem[sp_ff] <= wdata_ff[PC_W-1:0];
    end
  end

  always @(posedge aclk) begin
    if (rot_to_file) begin
      file_mem[faddr_ff] <= rot_res;
    end else if (wr_do && wa_file && lane0) begin
      file_mem[wa_fidx] <= wdata_ff[7:0];
    end
  end

  // ************************************************
  // axi4-lite read channel
  // ************************************************
  assign s_axi_arready = !s_axi_rvalid;
  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  wire ra_file = (ra >= `RRX_OFF_FILE) && ({1'b0, ra} < `RRX_OFF_FILE_END);
  reg [31:0] rd_val;
  reg rd_ok;

  always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (ra_file) begin
      rd_val[7:0] = file_mem[ra[8:2]];
    end else begin
      case (ra)
        `RRX_OFF_EXEC: rd_val = 32'h00000000;
        `RRX_OFF_STATUS: begin
          rd_val[`RRX_ST_CARRY_BIT] = carry_ff;
          rd_val[`RRX_ST_BUSY_BIT] = busy;
          rd_val[`RRX_ST_DEPTH_LSB +: PTR_W] = sp_ff;
        end
        `RRX_OFF_ACCUM: rd_val[7:0] = accumulator_ff;
        `RRX_OFF_IRQCTL: rd_val[7:0] = irq_control_ff;
        `RRX_OFF_PC: rd_val[PC_W-1:0] = pc_ff;
        `RRX_OFF_PUSH: rd_val = 32'h00000000;
        `RRX_OFF_TOP: rd_val[PC_W-1:0] = stack_top;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RRX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `RRX_RESP_OKAY : `RRX_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: rrx_exec_asserts.sv */
// port checks for the return and rotate unit
// assumes binding onto rrx_exec, one clock domain
`timescale 1ns/1ps
module rrx_exec_asserts #(
  parameter INSTR_DIV = 4,
  parameter PC_W = 13
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus answers
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  // core state
  input wire [PC_W-1:0] pc_out,
  input wire global_irq_enable,
  input wire busy
);
  // ****
  // helper and assertions
  // ****
  reg [7:0] busy_cnt_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always @(posedge aclk) begin
    if (!aresetn)
      busy_cnt_ff <= 8'h00;
    else
      busy_cnt_ff <= busy ? busy_cnt_ff + 8'h01 : 8'h00;
  end
  a_busy_bound: assert property (busy_cnt_ff <= 2 * INSTR_DIV + 1)
    else $error("busy too long");
  a_busy_cause: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
    else $error("busy without exec write");
  a_pc_rotate: assert property ($changed(pc_out) && !busy |-> pc_out == $past(pc_out) + 1'b1)
    else $error("rotate pc step wrong");
  a_pc_return: assert property ($changed(pc_out) && busy |-> busy[*2] ##[1:30] !busy)
    else $error("return not two cycles");
  a_gie_set: assert property ($rose(global_irq_enable) |-> busy || $rose(s_axi_bvalid))
    else $error("enable rose without cause");
  a_gie_clear: assert property ($fell(global_irq_enable) |-> $rose(s_axi_bvalid))
    else $error("enable fell without write");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  c_rotate: cover property ($fell(busy) && $changed(pc_out));
  c_return: cover property ($changed(pc_out) && busy);
  c_gie: cover property ($rose(global_irq_enable) && busy);
endmodule

/* File: rrx_exec_tb.sv */
// self-checking bench for rrx_exec over its register bus
// assumes rrx_defs.vh on the include path
`timescale 1ns/1ps
`include "rrx_defs.vh"
module rrx_exec_tb;
  // ****
  // signals and tasks
  // ****
  localparam DIV = 4;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire busy, global_irq_enable;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [12:0] pc_out;
  integer bad_count = 0, checks_done = 0, n, i, bcnt;
  reg [31:0] rd;
  reg [7:0] f, x;
  reg c;
  rrx_exec #(.INSTR_DIV(DIV)) rrx_exec_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pc_out(pc_out), .global_irq_enable(global_irq_enable), .busy(busy)
  );
  initial forever #20 aclk = ~aclk;
  task give_verdict; begin
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end endtask
  task chk(input [31:0] got, input [31:0] exp); begin
    checks_done = checks_done + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task tmo; begin
    bad_count = bad_count + 1;
    $display("CHECK FAILED %0t no answer", $time);
    give_verdict;
  end endtask
  // address and data offered together, each dropped once taken
  task wr(input [11:0] a, input [31:0] d, input [1:0] er); begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n = n + 1;
      if (n > 50) tmo;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
  end endtask
  task rdr(input [11:0] a, input [1:0] er); begin
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      n = n + 1;
      if (n > 50) tmo;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    chk(s_axi_rresp, er);
    s_axi_rready <= 0;
  end endtask
  task rdc(input [11:0] a, input [31:0] e); begin
    rdr(a, `RRX_RESP_OKAY);
    chk(rd, e);
  end endtask
  // busy is polled a step after each edge so the edge's updates land first
  task run(input [17:0] w, input ret); begin
    wr(`RRX_OFF_EXEC, {14'h0, w}, `RRX_RESP_OKAY);
    bcnt = 0;
    #1;
    while (busy) begin
      @(posedge aclk);
      #1;
      bcnt = bcnt + 1;
      if (bcnt > 40) tmo;
    end
    chk(ret ? (bcnt >= DIV && bcnt <= 2 * DIV + 1) : (bcnt <= DIV + 1), 1);
  end endtask
  // ****
  // scenarios
  // ****
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rdc(`RRX_OFF_ACCUM, 0);
    rdc(`RRX_OFF_IRQCTL, 0);
    rdc(`RRX_OFF_PC, 0);
    rdc(`RRX_OFF_STATUS, 0);
    rdr(12'h020, `RRX_RESP_SLVERR);
    chk(rd, 0);
    wr(12'h020, 1, `RRX_RESP_SLVERR);
    // both directions, both destinations, both carry values
    for (i = 0; i < 4; i = i + 1) begin
      f = 8'hE6 ^ i[7:0];
      c = i[1] ^ i[0];
      wr(`RRX_OFF_FILE + 12'h014, {24'h0, f}, `RRX_RESP_OKAY);
      wr(`RRX_OFF_STATUS, {31'h0, c}, `RRX_RESP_OKAY);
      wr(`RRX_OFF_ACCUM, 32'h3C, `RRX_RESP_OKAY);
      run({1'b1, i[1], i[0], 7'h05, 8'h00}, 0);
      x = i[1] ? {c, f[7:1]} : {f[6:0], c};
      rdc(`RRX_OFF_ACCUM, i[0] ? 32'h3C : {24'h0, x});
      rdc(`RRX_OFF_FILE + 12'h014, {24'h0, i[0] ? x : f});
      rdc(`RRX_OFF_STATUS, {31'h0, i[1] ? f[0] : f[7]});
      rdc(`RRX_OFF_PC, i + 1);
    end
    wr(`RRX_OFF_PUSH, 32'h123, `RRX_RESP_OKAY);
    wr(`RRX_OFF_STATUS, 1, `RRX_RESP_OKAY);
    rdc(`RRX_OFF_STATUS, 32'h11);
    run({2'h0, 16'h0000}, 1);
    rdc(`RRX_OFF_PC, 32'h123);
    chk(pc_out, 32'h123);
    rdc(`RRX_OFF_IRQCTL, 32'h80);
    chk(global_irq_enable, 1);
    rdc(`RRX_OFF_STATUS, 1);
    wr(`RRX_OFF_PUSH, 32'h0AA, `RRX_RESP_OKAY);
    run({2'h1, 16'h00A5}, 1);
    rdc(`RRX_OFF_ACCUM, 32'hA5);
    rdc(`RRX_OFF_PC, 32'hAA);
    rdc(`RRX_OFF_STATUS, 1);
    give_verdict;
  end
endmodule
bind rrx_exec rrx_exec_asserts #(.INSTR_DIV(INSTR_DIV), .PC_W(PC_W)) rrx_exec_asserts_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .pc_out(pc_out), .global_irq_enable(global_irq_enable), .busy(busy)
);
